// ### design/qlp_pkg.sv
// Shared constants, types and decode helpers for the quadrature LO phase select block.
// Assumes a single APB clock domain; all pins are synchronous to pclk.
package qlp_pkg;

  // ****************************************
  // Serial word layout
  // ****************************************
  localparam int WORD_W = 20;
  localparam int NUM_CH = 4;
  localparam int CODE_W = 4;
  localparam int FIELD_W = 5;
  localparam int EN_POS = 4;
  localparam int QUAD_W = 2;
  localparam int PH_QUAD_LSB = 2;
  localparam int PH_FINE_LSB = 0;

  // ****************************************
  // APB register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WORD = 8'h04;
  localparam logic [7:0] ADDR_SHIFT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int CTRL_SER_RST = 0;
  localparam int CTRL_DIV_SYNC = 1;
  localparam int ST_DIV_LSB = 0;
  localparam int ST_LO_I = 2;
  localparam int ST_LO_Q = 3;
  localparam int ST_ANY_EN = 4;
  localparam int ST_SDO = 5;
  localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    QLP_Q0 = 2'b00,
    QLP_Q1 = 2'b01,
    QLP_Q2 = 2'b10,
    QLP_Q3 = 2'b11
  } qlp_quad_t;

  typedef struct packed {
    logic power_on;
    logic lo_i;
    logic lo_q;
    logic [QUAD_W-1:0] fine_step;
  } qlp_chan_t;

  // ****************************************
  // Decoders
  // ****************************************
  // I high in quadrants 0 and 1: two of four steps, so 50% whatever the input duty
  function automatic logic lo_i_of(input logic [1:0] s);
    return ~s[1];
  endfunction : lo_i_of

  // Q high in quadrants 1 and 2: lags I by one step
  function automatic logic lo_q_of(input logic [1:0] s);
    return s[0] ^ s[1];
  endfunction : lo_q_of

  function automatic logic [FIELD_W-1:0] chan_field(input logic [WORD_W-1:0] w, input int n);
    return w[n*FIELD_W +: FIELD_W];
  endfunction : chan_field

endpackage : qlp_pkg

// ### design/qlp_quad_divider.sv
// Divide-by-4 quadrant counter with registered I/Q LO phases.
// Assumes lo_rise is a one-cycle strobe per rising edge of the 4x LO input.
`timescale 1ns/1ps
module qlp_quad_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic lo_rise,
  input wire logic run,
  input wire logic sync_reset,
  output qlp_pkg::qlp_quad_t quad_state,
  output qlp_pkg::qlp_quad_t quad_next,
  output logic lo_i,
  output logic lo_q
);

  typedef struct packed {
    qlp_pkg::qlp_quad_t quad;
    logic lo_i;
    logic lo_q;
  } qlp_div_state_t;

  qlp_div_state_t q;
  qlp_div_state_t d;
  qlp_pkg::qlp_quad_t step;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    case (q.quad)
      qlp_pkg::QLP_Q0: step = qlp_pkg::QLP_Q1; // R15
      qlp_pkg::QLP_Q1: step = qlp_pkg::QLP_Q2;
      qlp_pkg::QLP_Q2: step = qlp_pkg::QLP_Q3;
      qlp_pkg::QLP_Q3: step = qlp_pkg::QLP_Q0;
      default: step = qlp_pkg::QLP_Q0;
    endcase
    quad_next = q.quad;
    if (run) begin
      if (sync_reset) begin
        quad_next = qlp_pkg::QLP_Q0; // R09
      end else if (lo_rise) begin
        quad_next = step; // R01
      end
    end
    d.quad = quad_next; // R11
    // Only LO edges and sync reset move these flops, so divider ripple never reaches them
    if (lo_rise || sync_reset) begin
      d.lo_i = run & qlp_pkg::lo_i_of(quad_next); // R03 R02
      d.lo_q = run & qlp_pkg::lo_q_of(quad_next); // R02
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign quad_state = q.quad;
  assign lo_i = q.lo_i;
  assign lo_q = q.lo_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_div_step;
    (clk_en && run && lo_rise && !sync_reset) |=> (quad_state == qlp_pkg::qlp_quad_t'($past(quad_state) + 2'b01));
  endproperty
  a_div_step: assert property (p_div_step) else $error("divider did not advance one quadrant"); // R15

  property p_div_sync;
    (clk_en && run && sync_reset) |=> (quad_state == qlp_pkg::QLP_Q0) ##1 (!$past(lo_rise) || lo_i || !run);
  endproperty
  a_div_sync: assert property (p_div_sync) else $error("divider sync reset did not reach quadrant 0"); // R09

  property p_div_idle;
    (!run) |=> $stable(quad_state);
  endproperty
  a_div_idle: assert property (p_div_idle) else $error("divider moved with all channels off"); // R11

endmodule : qlp_quad_divider

// ### design/qlp_lo_phase_select.sv
// Digital core of a four-channel I/Q demodulator: serial control word, LO divider, phase select.
// Assumes APB master on pclk; LO and serial pins already synchronous to pclk.
//
// Operation
// R01 - Internal 0 and 90 degree LO phases come from dividing the 4x LO by four.
// R02 - Both quadrature LO phases keep 50% duty regardless of 4x LO duty.
// R03 - Final LO flip-flops are retimed directly by the 4x LO edge.
// R04 - Each of four channels offers sixteen phase shifts, 22.5 degrees apart.
// R05 - Phase code is 4-bit unsigned, shift equals code times 22.5 degrees.
// R06 - Equal codes give in-phase outputs; one step higher leads by 22.5 degrees.
// R07 - Channel phase comes from the latched word, never from the shift register.
// R08 - Serial control reset clears every control bit, shift register and latch.
// R09 - LO divider reset forces the divider into a fixed known quadrant.
// R10 - With several devices, the controller drives the divider reset after power-up.
// R11 - LO interface and divider reset act only while some channel is enabled.
// R12 - 20-bit shift register, MSB first, latched on rising edge of select.
// R13 - Serial data sampled on serial clock rise; daisy output changes on that rise.
// R14 - All enables zero powers down all but the serial port.
// R15 - Divider advances one quadrant per 4x LO rising edge, four states.
// R16 - Each channel picks one of sixteen phase states, held until new latch.
`timescale 1ns/1ps
module qlp_lo_phase_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qlp_pkg::ADDR_W-1:0] paddr,
  input wire logic [qlp_pkg::DATA_W-1:0] pwdata,
  output logic [qlp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic quad_lo_in_pos,
  input wire logic quad_lo_in_neg,
  input wire logic lo_divider_sync_reset,
  input wire logic serial_control_reset,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic select_active_low,
  output logic sdo,
  output qlp_pkg::qlp_chan_t [qlp_pkg::NUM_CH-1:0] chan_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [qlp_pkg::WORD_W-1:0] shift;
    logic [qlp_pkg::WORD_W-1:0] latch;
    logic sdo;
    logic lo_prev;
    logic sclk_prev;
    logic sel_prev;
    qlp_pkg::qlp_chan_t [qlp_pkg::NUM_CH-1:0] ch;
    logic [qlp_pkg::DATA_W-1:0] prdata;
    logic pslverr;
    logic acc_ok;
  } qlp_top_state_t;

  qlp_top_state_t q;
  qlp_top_state_t d;

  // Active-low select idles high: a zero here would latch a false frame after reset
  localparam qlp_top_state_t TOP_RST = '{sel_prev: 1'b1, default: '0};

  logic lo_lvl;
  logic lo_rise;
  logic sclk_rise;
  logic sel_rise;
  logic any_en;
  logic wr_done;
  logic ser_clear;
  logic div_sync;
  qlp_pkg::qlp_quad_t quad_state;
  qlp_pkg::qlp_quad_t quad_next;
  logic div_lo_i;
  logic div_lo_q;
  logic [qlp_pkg::FIELD_W-1:0] ch_field [qlp_pkg::NUM_CH];
  logic [qlp_pkg::QUAD_W-1:0] ch_quad [qlp_pkg::NUM_CH];

  function automatic logic addr_is(input logic [qlp_pkg::ADDR_W-1:0] a,
                                   input logic [qlp_pkg::ADDR_W-1:0] reg_addr);
    return a == reg_addr;
  endfunction : addr_is

  // ****************************************
  // Edge strobes
  // ****************************************
  // Differential pair: count only a clean high, so a stuck pair never clocks
  assign lo_lvl = quad_lo_in_pos & ~quad_lo_in_neg;
  assign lo_rise = lo_lvl & ~q.lo_prev;
  assign sclk_rise = sclk & ~q.sclk_prev; // R13
  assign sel_rise = select_active_low & ~q.sel_prev; // R12

  // ****************************************
  // APB slave
  // ****************************************
  // One wait-free access phase once the setup cycle ran with clk_en high
  assign pready = clk_en & penable & q.acc_ok;
  assign wr_done = psel & penable & pready & pwrite;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;

  assign ser_clear = serial_control_reset
                   | (wr_done & addr_is(paddr, qlp_pkg::ADDR_CTRL) & pwdata[qlp_pkg::CTRL_SER_RST]);
  assign div_sync = lo_divider_sync_reset
                  | (wr_done & addr_is(paddr, qlp_pkg::ADDR_CTRL) & pwdata[qlp_pkg::CTRL_DIV_SYNC]);

  // ****************************************
  // Channel decode
  // ****************************************
  for (genvar n = 0; n < qlp_pkg::NUM_CH; n++) begin : g_ch
    assign ch_field[n] = qlp_pkg::chan_field(q.latch, n); // R07
    // Quadrant part of the code advances the LO state: each quadrant leads by 90 degrees
    assign ch_quad[n] = quad_next + ch_field[n][qlp_pkg::PH_QUAD_LSB +: qlp_pkg::QUAD_W]; // R05 R06
  end

  always_comb begin
    any_en = 1'b0;
    for (int n = 0; n < qlp_pkg::NUM_CH; n++) begin
      any_en = any_en | ch_field[n][qlp_pkg::EN_POS];
    end
  end

  // ****************************************
  // Divider
  // ****************************************
  qlp_quad_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .lo_rise(lo_rise),
    .run(any_en),
    .sync_reset(div_sync),
    .quad_state(quad_state),
    .quad_next(quad_next),
    .lo_i(div_lo_i),
    .lo_q(div_lo_q)
  ); // R01 R11

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.lo_prev = lo_lvl;
    d.sclk_prev = sclk;
    d.sel_prev = select_active_low;

    // Serial port stays alive even with every channel off
    if (sclk_rise) begin
      d.shift = {q.shift[qlp_pkg::WORD_W-2:0], sdi}; // R12 R13
      d.sdo = q.shift[qlp_pkg::WORD_W-2]; // R13
    end
    if (sel_rise) begin
      d.latch = q.shift; // R12
    end
    if (wr_done && addr_is(paddr, qlp_pkg::ADDR_WORD)) begin
      d.latch = pwdata[qlp_pkg::WORD_W-1:0];
    end
    if (ser_clear) begin
      d.shift = qlp_pkg::WORD_RST; // R08
      d.latch = qlp_pkg::WORD_RST; // R08
      d.sdo = 1'b0;
    end

    for (int n = 0; n < qlp_pkg::NUM_CH; n++) begin
      d.ch[n].power_on = ch_field[n][qlp_pkg::EN_POS];
      d.ch[n].fine_step = ch_field[n][qlp_pkg::PH_FINE_LSB +: qlp_pkg::QUAD_W]; // R04 R16
      if (!any_en || !ch_field[n][qlp_pkg::EN_POS]) begin
        d.ch[n].lo_i = 1'b0; // R14
        d.ch[n].lo_q = 1'b0; // R14
      end else if (lo_rise || div_sync) begin
        // New codes take effect only at the next LO edge or divider sync, keeping the phase glitch-free
        d.ch[n].lo_i = qlp_pkg::lo_i_of(ch_quad[n]); // R03 R16
        d.ch[n].lo_q = qlp_pkg::lo_q_of(ch_quad[n]); // R03 R16
      end
    end

    if (psel && !(penable && pready)) begin
      d.acc_ok = 1'b1;
      d.pslverr = 1'b0;
      case (paddr)
        qlp_pkg::ADDR_CTRL: d.prdata = '0;
        qlp_pkg::ADDR_WORD: d.prdata = {{(qlp_pkg::DATA_W-qlp_pkg::WORD_W){1'b0}}, q.latch};
        qlp_pkg::ADDR_SHIFT: d.prdata = {{(qlp_pkg::DATA_W-qlp_pkg::WORD_W){1'b0}}, q.shift};
        qlp_pkg::ADDR_STATUS: begin
          d.prdata = '0;
          d.prdata[qlp_pkg::ST_DIV_LSB +: qlp_pkg::QUAD_W] = quad_state;
          d.prdata[qlp_pkg::ST_LO_I] = div_lo_i;
          d.prdata[qlp_pkg::ST_LO_Q] = div_lo_q;
          d.prdata[qlp_pkg::ST_ANY_EN] = any_en;
          d.prdata[qlp_pkg::ST_SDO] = q.sdo;
        end
        default: begin
          d.prdata = '0;
          d.pslverr = 1'b1;
        end
      endcase
    end else if (psel && penable && pready) begin
      d.acc_ok = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= TOP_RST;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign sdo = q.sdo;
  assign chan_out = q.ch;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_shift_in;
    (clk_en && sclk_rise && !ser_clear)
      |=> (q.shift == {$past(q.shift[qlp_pkg::WORD_W-2:0]), $past(sdi)});
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift register missed serial bit"); // R13

  property p_sdo_edge;
    (clk_en && !sclk_rise && !ser_clear) |=> $stable(sdo);
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("daisy output moved without serial clock rise"); // R13

  property p_latch_sel;
    (clk_en && sel_rise && !ser_clear && !(wr_done && addr_is(paddr, qlp_pkg::ADDR_WORD)))
      |=> (q.latch == $past(q.shift));
  endproperty
  a_latch_sel: assert property (p_latch_sel) else $error("latch did not capture on select rise"); // R12

  property p_latch_hold;
    (clk_en && !sel_rise && !ser_clear && !wr_done) |=> $stable(q.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without select rise"); // R07

  property p_ser_clear;
    (clk_en && serial_control_reset) |=> (q.shift == '0) && (q.latch == '0) && !sdo;
  endproperty
  a_ser_clear: assert property (p_ser_clear) else $error("serial reset left control bits set"); // R08

  property p_power_down;
    (clk_en && !any_en) |=> (chan_out[0].lo_i == 1'b0) && (chan_out[3].lo_q == 1'b0);
  endproperty
  a_power_down: assert property (p_power_down) else $error("channel LO active while powered down"); // R14

  property p_phase_ch0;
    (clk_en && lo_rise && ch_field[0][qlp_pkg::EN_POS])
      |=> (chan_out[0].lo_i == qlp_pkg::lo_i_of($past(ch_quad[0])))
       && (chan_out[0].lo_q == qlp_pkg::lo_q_of($past(ch_quad[0])));
  endproperty
  a_phase_ch0: assert property (p_phase_ch0) else $error("channel 0 phase does not match code"); // R16

  property p_apb_ready;
    (clk_en && psel && !penable) |=> (penable && clk_en) |-> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB access not answered in one cycle");

  property p_lo_retime;
    (clk_en && !lo_rise && !div_sync && $stable(q.latch)) |=> $stable(chan_out[1].lo_i);
  endproperty
  a_lo_retime: assert property (p_lo_retime) else $error("channel LO moved between LO edges"); // R03

  property p_word_write;
    (clk_en && wr_done && addr_is(paddr, qlp_pkg::ADDR_WORD) && !ser_clear)
      |=> (q.latch == $past(pwdata[qlp_pkg::WORD_W-1:0]));
  endproperty
  a_word_write: assert property (p_word_write) else $error("word write did not load the latch");

  property p_sdo_shift;
    (clk_en && sclk_rise && !ser_clear) |=> (sdo == q.shift[qlp_pkg::WORD_W-1]);
  endproperty
  a_sdo_shift: assert property (p_sdo_shift) else $error("daisy output is not the shifted-out bit"); // R13

  property p_shift_hold;
    (clk_en && !sclk_rise && !ser_clear) |=> $stable(q.shift);
  endproperty
  a_shift_hold: assert property (p_shift_hold) else $error("shift register moved without serial clock rise"); // R13

  property p_stall;
    (!clk_en) |-> !pready;
  endproperty
  a_stall: assert property (p_stall) else $error("APB answered while the core was frozen");

  property p_access_once;
    (clk_en && psel && penable && pready) |=> !pready;
  endproperty
  a_access_once: assert property (p_access_once) else $error("APB ready stayed high after the access");

  // Unmapped offsets answer with an error and no data
  property p_bad_addr;
    (clk_en && psel && !penable && !addr_is(paddr, qlp_pkg::ADDR_CTRL) && !addr_is(paddr, qlp_pkg::ADDR_WORD)
     && !addr_is(paddr, qlp_pkg::ADDR_SHIFT) && !addr_is(paddr, qlp_pkg::ADDR_STATUS))
      |=> pslverr && (prdata == '0);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("unmapped access not refused");

  property p_status_read;
    (clk_en && psel && !penable && addr_is(paddr, qlp_pkg::ADDR_STATUS))
      |=> (prdata[qlp_pkg::ST_DIV_LSB +: qlp_pkg::QUAD_W] == $past(quad_state))
       && (prdata[qlp_pkg::ST_ANY_EN] == $past(any_en));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read does not show the divider"); // R15

  // Same code on channels 0 and 1 must give the same LO at every update
  property p_equal_codes;
    (clk_en && (lo_rise || div_sync) && (ch_field[0] == ch_field[1]))
      |=> (chan_out[0] == chan_out[1]);
  endproperty
  a_equal_codes: assert property (p_equal_codes) else $error("equal codes gave different channel LOs"); // R06

  // ****************************************
  // Per-channel checks
  // ****************************************
  for (genvar n = 0; n < qlp_pkg::NUM_CH; n++) begin : g_chk
    property p_chan_cfg;
      clk_en |=> (chan_out[n].power_on == $past(ch_field[n][qlp_pkg::EN_POS]))
        && (chan_out[n].fine_step == $past(ch_field[n][qlp_pkg::PH_FINE_LSB +: qlp_pkg::QUAD_W]));
    endproperty
    a_chan_cfg: assert property (p_chan_cfg) else $error("channel config does not follow latch"); // R04

    property p_chan_off;
      (clk_en && !ch_field[n][qlp_pkg::EN_POS]) |=> !chan_out[n].lo_i && !chan_out[n].lo_q;
    endproperty
    a_chan_off: assert property (p_chan_off) else $error("disabled channel still drives its LO"); // R14

    property p_chan_hold;
      (clk_en && !lo_rise && !div_sync && ch_field[n][qlp_pkg::EN_POS] && any_en)
        |=> $stable(chan_out[n].lo_i) && $stable(chan_out[n].lo_q);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel LO changed without LO edge"); // R16
  end

endmodule : qlp_lo_phase_select

// ### sim/qlp_host_model.sv
// Host controller model: drives the serial port and both reset pins.
// Assumes the bench calls its tasks from one process, synchronous to pclk.
`timescale 1ns/1ps
module qlp_host_model (
  input wire logic pclk,
  output logic sclk,
  output logic sdi,
  output logic select_active_low,
  output logic serial_control_reset,
  output logic lo_divider_sync_reset
);
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    select_active_low = 1'b1;
    serial_control_reset = 1'b0;
    lo_divider_sync_reset = 1'b0;
  end

  // MSB first; data set while clock low; gap stretches each high phase
  task automatic send_word(input logic [19:0] w, input int gap);
    // Select low for the whole frame; latch_word raises it again
    @(posedge pclk);
    select_active_low <= 1'b0;
    for (int i = 19; i >= 0; i--) begin
      @(posedge pclk);
      sclk <= 1'b0;
      sdi <= w[i];
      @(posedge pclk);
      sclk <= 1'b1;
      repeat (gap) @(posedge pclk);
    end
    @(posedge pclk);
    sclk <= 1'b0;
    // Data line means nothing between frames
    sdi <= ~w[0];
  endtask : send_word

  task automatic latch_word();
    @(posedge pclk);
    select_active_low <= 1'b1;
    // Select stays high: the port idles deselected until the next frame
    @(posedge pclk);
  endtask : latch_word

  // Level pulse on one reset pin: 0 serial clear, 1 divider sync
  task automatic pulse(input bit which);
    @(posedge pclk);
    if (which) lo_divider_sync_reset <= 1'b1;
    else serial_control_reset <= 1'b1;
    @(posedge pclk);
    lo_divider_sync_reset <= 1'b0;
    serial_control_reset <= 1'b0;
  endtask : pulse
endmodule : qlp_host_model

// ### sim/qlp_lo_phase_select_tb.sv
// Self-checking bench for the LO phase select core.
// Assumes the host model in its own file; clk_en dropped once to check the freeze.
`timescale 1ns/1ps
module qlp_lo_phase_select_tb;
  localparam logic [19:0] W = 20'hfd230;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic lo_pos = 1'b0;
  logic lo_neg = 1'b1;
  logic clk_en = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, sdo, sclk, sdi, sel_n, ser_rst, div_sync;
  qlp_pkg::qlp_chan_t [qlp_pkg::NUM_CH-1:0] chan_out;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;

  always #5 pclk = ~pclk;

  qlp_host_model u_host (.pclk(pclk), .sclk(sclk), .sdi(sdi), .select_active_low(sel_n),
    .serial_control_reset(ser_rst), .lo_divider_sync_reset(div_sync));

  qlp_lo_phase_select u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .quad_lo_in_pos(lo_pos), .quad_lo_in_neg(lo_neg),
    .lo_divider_sync_reset(div_sync), .serial_control_reset(ser_rst), .sclk(sclk),
    .sdi(sdi), .select_active_low(sel_n), .sdo(sdo), .chan_out(chan_out));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic lo_tick();
    @(posedge pclk);
    lo_pos <= 1'b1;
    lo_neg <= 1'b0;
    @(posedge pclk);
    lo_pos <= 1'b0;
    lo_neg <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : lo_tick

  // Channel LO follows divider quadrant plus the two high code bits
  task automatic chk_lo(input logic [1:0] q, input logic on);
    logic [1:0] c;
    apb(1'b0, 8'h0c, 32'h0);
    chk("quadrant", {30'h0, q}, {30'h0, rd[1:0]});
    chk("div i q", {30'h0, ~q[1], q[0] ^ q[1]}, {30'h0, rd[2], rd[3]});
    for (int n = 0; n < 4; n++) begin
      c = q + W[5*n+2 +: 2];
      chk("chan lo", {30'h0, on & ~c[1], on & (c[0] ^ c[1])}, {30'h0, chan_out[n].lo_i, chan_out[n].lo_q});
    end
  endtask : chk_lo

  task automatic t_reset();
    chk("chan after reset", 32'h0, {12'h0, chan_out});
    apb(1'b0, 8'h04, 32'h0);
    chk("word after reset", 32'h0, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_program();
    u_host.send_word(W, 2);
    repeat (2) @(posedge pclk);
    chk("unlatched power", 32'h0, {28'h0, chan_out[3].power_on, chan_out[2].power_on,
      chan_out[1].power_on, chan_out[0].power_on});
    chk("daisy out", {31'h0, W[19]}, {31'h0, sdo});
    apb(1'b0, 8'h08, 32'h0);
    chk("shift", {12'h0, W}, rd);
    u_host.latch_word();
    repeat (2) @(posedge pclk);
    for (int n = 0; n < 4; n++) begin
      chk("power", 32'h1, {31'h0, chan_out[n].power_on});
      chk("fine", {30'h0, W[5*n +: 2]}, {30'h0, chan_out[n].fine_step});
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("word", {12'h0, W}, rd);
    $display("test program done");
  endtask : t_program

  task automatic t_lo();
    logic [1:0] q;
    u_host.pulse(1'b1);
    repeat (2) @(posedge pclk);
    q = 2'd0;
    chk_lo(q, 1'b1);
    for (int k = 0; k < 5; k++) begin
      lo_tick();
      q = q + 2'd1;
      chk_lo(q, 1'b1);
    end
    // Frozen core must not count an LO edge
    clk_en <= 1'b0;
    lo_tick();
    clk_en <= 1'b1;
    chk_lo(q, 1'b1);
    apb(1'b1, 8'h00, 32'h2);
    q = 2'd0;
    chk_lo(q, 1'b1);
    apb(1'b1, 8'h04, 32'h0);
    u_host.pulse(1'b1);
    lo_tick();
    apb(1'b0, 8'h0c, 32'h0);
    chk("frozen quadrant", {30'h0, q}, {30'h0, rd[1:0]});
    chk("any enable", 32'h0, {31'h0, rd[4]});
    chk("lo off", 32'h0, {12'h0, chan_out});
    $display("test lo done");
  endtask : t_lo

  task automatic t_clear();
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    apb(1'b1, 8'h04, {12'h0, W});
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk("shift read only", {12'h0, W}, rd);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("ctrl clear", 32'h0, rd);
    u_host.send_word(W, 0);
    u_host.latch_word();
    u_host.pulse(1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk("pin clear shift", 32'h0, rd);
    chk("pin clear chan", 32'h0, {12'h0, chan_out});
    $display("test clear done");
  endtask : t_clear

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_program();
    t_lo();
    t_clear();
    wrap_up();
  end
endmodule : qlp_lo_phase_select_tb
